// ---- src/flash_host_ctrl.sv ----
// host-side controller for a boot-block flash on its asynchronous parallel bus
// Overview of operation
// - top data pin is data bit 15 in word width, low address in byte width.
// - programming supply stays high from confirm cycle until the operation completes.
// - erase confirm D0h is written only right after erase setup 20h.
// - data to program is written only right after a program setup command.
// - read array FFh is issued after write or erase before reading the array.
`timescale 1ns/1ns
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int unsigned PROG_WAIT_CYC = PROG_WAIT_DEF,
  parameter int unsigned ERASE_WAIT_CYC = ERASE_WAIT_DEF,
  parameter logic [7:0] ID_CMD = CMD_IDENTIFY_DEF
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire logic [2:0] REQ_OP,
  input wire logic [USER_ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  input wire logic REQ_BOOT,
  input wire logic BYTE_MODE,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [DATA_W-1:0] RSP_DATA,
  output logic FL_CE_N,
  output logic FL_OE_N,
  output logic FL_WE_N,
  output logic FL_RESET_POWERDOWN_N,
  output logic FL_WP,
  output logic FL_BYTE_N,
  output logic FL_ID_ELEVATED_VOLTAGE,
  output logic FL_VPP_EN,
  output logic [PIN_ADDR_W-1:0] FL_ADDR,
  output logic [DATA_W-1:0] FL_DQ_O,
  output logic [DATA_W-1:0] FL_DQ_OE,
  input wire logic [DATA_W-1:0] FL_DQ_I
);

  localparam top_s TOP_RST = '{st: T_RESET, op: OP_READ,
                               cnt: WAIT_CNT_W'(RESET_CYC - 1), default: '0};

  top_s s_r;
  top_s s_nxt;
  flash_cycle_if cif ();

  // queue one bus cycle on the sequencer
  function automatic top_s issue(input top_s t, input logic wr,
                                 input logic [USER_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    t.req = 1'h1;
    t.wr = wr;
    t.caddr = a;
    t.cdata = d;
    return t;
  endfunction

  // ********************************
  // command sequencing
  // ********************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.req = 1'h0;
    s_nxt.rsp_valid = 1'h0;
    if (cif.done && s_r.wr) begin
      s_nxt.last_cmd = s_r.cdata[LOW_W-1:0];
    end
    case (s_r.st)
      T_RESET: begin
        // device state is known to us afterwards only as array read
        s_nxt.reset_powerdown_n = 1'h0;
        s_nxt.array_mode = 1'h1;
        if (s_r.cnt == '0) begin
          s_nxt.reset_powerdown_n = 1'h1;
          s_nxt.ready = 1'h1;
          s_nxt.st = T_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'h1;
        end
      end
      T_IDLE: begin
        if (REQ_VALID && s_r.ready) begin
          s_nxt.ready = 1'h0;
          s_nxt.op = op_e'(REQ_OP);
          s_nxt.addr = REQ_ADDR;
          s_nxt.wdata = REQ_WDATA;
          s_nxt.byte_m = BYTE_MODE;
          case (REQ_OP)
            OP_READ: begin
              if (s_r.array_mode) begin
                s_nxt = issue(s_nxt, 1'h0, REQ_ADDR, '0);
                s_nxt.st = T_READ;
              end else begin
                s_nxt = issue(s_nxt, 1'h1, REQ_ADDR, DATA_W'(CMD_READ_ARRAY));
                s_nxt.st = T_ARRAY;
              end
            end
            OP_PROGRAM: begin
              s_nxt.wp = REQ_BOOT;
              s_nxt.vpp = 1'h1;
              s_nxt = issue(s_nxt, 1'h1, REQ_ADDR, DATA_W'(CMD_PROG_SETUP));
              s_nxt.st = T_SETUP_CMD;
            end
            OP_ERASE: begin
              s_nxt.wp = REQ_BOOT;
              s_nxt.vpp = 1'h1;
              s_nxt = issue(s_nxt, 1'h1, REQ_ADDR, DATA_W'(CMD_ERASE_SETUP));
              s_nxt.st = T_SETUP_CMD;
            end
            OP_ID_CMD: begin
              s_nxt = issue(s_nxt, 1'h1, REQ_ADDR, DATA_W'(ID_CMD));
              s_nxt.st = T_ID_CMD;
            end
            OP_ID_HV: begin
              // elevated level is raised with the read request, one cycle before the address setup
              s_nxt.a9_hv = 1'h1;
              s_nxt = issue(s_nxt, 1'h0, REQ_ADDR, '0);
              s_nxt.st = T_READ;
            end
            OP_RESET: begin
              s_nxt.reset_powerdown_n = 1'h0;
              s_nxt.cnt = WAIT_CNT_W'(RESET_CYC - 1);
              s_nxt.st = T_RESET;
            end
            default: begin
              s_nxt.ready = 1'h1;
            end
          endcase
        end
      end
      T_SETUP_CMD: begin
        if (cif.done) begin
          if (s_r.op == OP_PROGRAM) begin
            s_nxt = issue(s_nxt, 1'h1, s_r.addr, s_r.wdata);
          end else begin
            s_nxt = issue(s_nxt, 1'h1, s_r.addr, DATA_W'(CMD_ERASE_CONFIRM));
          end
          s_nxt.st = T_CONFIRM;
        end
      end
      T_CONFIRM: begin
        if (cif.done) begin
          s_nxt.array_mode = 1'h0;
          s_nxt.cnt = (s_r.op == OP_PROGRAM) ? WAIT_CNT_W'(PROG_WAIT_CYC - 1)
                                            : WAIT_CNT_W'(ERASE_WAIT_CYC - 1);
          s_nxt.st = T_WAIT;
        end
      end
      T_WAIT: begin
        // no status polling: supply is held for the whole worst-case time
        if (s_r.cnt == '0) begin
          s_nxt.vpp = 1'h0;
          s_nxt.wp = 1'h0;
          s_nxt.rsp_valid = 1'h1;
          s_nxt.rsp_data = '0;
          s_nxt.ready = 1'h1;
          s_nxt.st = T_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'h1;
        end
      end
      T_ARRAY: begin
        if (cif.done) begin
          s_nxt.array_mode = 1'h1;
          s_nxt = issue(s_nxt, 1'h0, s_r.addr, '0);
          s_nxt.st = T_READ;
        end
      end
      T_ID_CMD: begin
        if (cif.done) begin
          s_nxt.array_mode = 1'h0;
          s_nxt = issue(s_nxt, 1'h0, s_r.addr, '0);
          s_nxt.st = T_READ;
        end
      end
      default: begin
        if (cif.done) begin
          s_nxt.rsp_data = cif.rdata;
          s_nxt.rsp_valid = 1'h1;
          s_nxt.a9_hv = 1'h0;
          s_nxt.ready = 1'h1;
          s_nxt.st = T_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s_r <= TOP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ********************************
  // sequencer and pins
  // ********************************
  assign cif.req = s_r.req;
  assign cif.wr = s_r.wr;
  assign cif.byte_m = s_r.byte_m;
  assign cif.addr = s_r.caddr;
  assign cif.wdata = s_r.cdata;
  assign cif.dq_i = FL_DQ_I;

  flash_cycle_seq u_seq (
    .clk(CLOCK),
    .rst(RST),
    .cif(cif)
  );

  assign REQ_READY = s_r.ready;
  assign RSP_VALID = s_r.rsp_valid;
  assign RSP_DATA = s_r.rsp_data;
  assign FL_RESET_POWERDOWN_N = s_r.reset_powerdown_n;
  assign FL_WP = s_r.wp;
  assign FL_ID_ELEVATED_VOLTAGE = s_r.a9_hv;
  assign FL_VPP_EN = s_r.vpp;
  assign FL_CE_N = cif.ce_n;
  assign FL_OE_N = cif.oe_n;
  assign FL_WE_N = cif.we_n;
  assign FL_BYTE_N = cif.byte_n;
  assign FL_ADDR = cif.pin_addr;
  assign FL_DQ_O = cif.dq_o;
  assign FL_DQ_OE = cif.dq_oe;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  AST_CONFIRM_VPP: assert property ((s_r.st == T_CONFIRM && !FL_WE_N) |-> FL_VPP_EN)
    else $error("confirm strobe without programming supply");
  AST_VPP_HOLD: assert property (s_r.st == T_WAIT |-> FL_VPP_EN && $stable(FL_VPP_EN))
    else $error("supply dropped before operation end");
  AST_ERASE_PAIR: assert property (
    (s_r.req && s_r.cdata[LOW_W-1:0] == CMD_ERASE_CONFIRM && s_r.op == OP_ERASE)
      |-> s_r.last_cmd == CMD_ERASE_SETUP)
    else $error("erase confirm not preceded by erase setup");
  AST_PROG_PAIR: assert property (
    (s_r.req && s_r.wr && s_r.st == T_CONFIRM && s_r.op == OP_PROGRAM)
      |-> s_r.last_cmd == CMD_PROG_SETUP)
    else $error("program data not preceded by program setup");
  AST_ARRAY_READ: assert property (
    (s_r.req && !s_r.wr && s_r.op == OP_READ) |-> s_r.array_mode && !$past(s_r.vpp))
    else $error("array read without read array mode");
  AST_RESET_LOW: assert property (
    (s_r.st == T_IDLE && REQ_VALID && s_r.ready && REQ_OP == OP_RESET)
      |=> !FL_RESET_POWERDOWN_N [*2])
    else $error("reset pulse too short");

  COV_ERASE: cover property (s_r.st == T_WAIT && s_r.op == OP_ERASE ##1 s_r.st == T_IDLE);
  COV_PROG: cover property (s_r.st == T_WAIT && s_r.op == OP_PROGRAM ##1 s_r.st == T_IDLE);
  COV_ID_HV: cover property (FL_ID_ELEVATED_VOLTAGE && !FL_OE_N);
  COV_BYTE_RD: cover property (!FL_BYTE_N && !FL_OE_N);

endmodule

// ---- src/flash_host_pkg.sv ----
// constants, types and state layouts for the flash host controller
package flash_host_pkg;

  // ********************************
  // clock and timing
  // ********************************
  localparam int CLK_NS = 20;

  // least times round up to whole cycles
  function automatic int ns_to_cyc(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  localparam int ADDR_SETUP_NS = 40;
  localparam int STROBE_NS = 100;
  localparam int HOLD_NS = 40;
  localparam int RESET_LOW_NS = 200;
  localparam int PROG_WAIT_US = 20;
  localparam int ERASE_WAIT_MS = 1000;

  localparam int SETUP_CYC = ns_to_cyc(ADDR_SETUP_NS);
  localparam int STROBE_CYC = ns_to_cyc(STROBE_NS);
  localparam int HOLD_CYC = ns_to_cyc(HOLD_NS);
  localparam int RESET_CYC = ns_to_cyc(RESET_LOW_NS);
  localparam int PROG_WAIT_DEF = PROG_WAIT_US * 1000 / CLK_NS;
  localparam int ERASE_WAIT_DEF = ERASE_WAIT_MS * 1000000 / CLK_NS;

  // ********************************
  // widths
  // ********************************
  localparam int DATA_W = 16;
  localparam int LOW_W = 8;
  localparam int PIN_ADDR_W = 19;
  localparam int USER_ADDR_W = 20;
  localparam int SEQ_CNT_W = 4;
  localparam int WAIT_CNT_W = 27;

  // ********************************
  // command codes
  // ********************************
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_IDENTIFY_DEF = 8'h90;

  // ********************************
  // types
  // ********************************
  typedef enum logic [2:0] {OP_READ, OP_PROGRAM, OP_ERASE, OP_ID_CMD, OP_ID_HV, OP_RESET} op_e;
  typedef enum logic [2:0] {
    T_RESET, T_IDLE, T_ARRAY, T_SETUP_CMD, T_CONFIRM, T_WAIT, T_ID_CMD, T_READ
  } top_st_e;
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} seq_st_e;

  typedef struct packed {
    seq_st_e st;
    logic [SEQ_CNT_W-1:0] cnt;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic byte_n;
    logic wr;
    logic done;
    logic [PIN_ADDR_W-1:0] pin_addr;
    logic [DATA_W-1:0] dq_o;
    logic [DATA_W-1:0] dq_oe;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic [DATA_W-1:0] rdata;
  } seq_s;

  typedef struct packed {
    top_st_e st;
    op_e op;
    logic [WAIT_CNT_W-1:0] cnt;
    logic [USER_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic array_mode;
    logic ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic reset_powerdown_n;
    logic wp;
    logic a9_hv;
    logic vpp;
    logic req;
    logic wr;
    logic byte_m;
    logic [USER_ADDR_W-1:0] caddr;
    logic [DATA_W-1:0] cdata;
    logic [7:0] last_cmd;
  } top_s;

endpackage

// ---- src/flash_cycle_if.sv ----
// bus-cycle request and pin-state bundle between controller and cycle sequencer
`timescale 1ns/1ns
interface flash_cycle_if;
  import flash_host_pkg::*;
  logic req;
  logic wr;
  logic byte_m;
  logic [USER_ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] dq_i;
  logic done;
  logic [DATA_W-1:0] rdata;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic byte_n;
  logic [PIN_ADDR_W-1:0] pin_addr;
  logic [DATA_W-1:0] dq_o;
  logic [DATA_W-1:0] dq_oe;

  modport ctrl (output req, wr, byte_m, addr, wdata, dq_i,
                input done, rdata, ce_n, oe_n, we_n, byte_n, pin_addr, dq_o, dq_oe);
  modport seq (input req, wr, byte_m, addr, wdata, dq_i,
               output done, rdata, ce_n, oe_n, we_n, byte_n, pin_addr, dq_o, dq_oe);
endinterface

// ---- src/flash_cycle_seq.sv ----
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/1ns
module flash_cycle_seq
  import flash_host_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  flash_cycle_if.seq cif
);

  localparam seq_s SEQ_RST = '{st: S_IDLE, ce_n: 1'h1, oe_n: 1'h1, we_n: 1'h1, byte_n: 1'h1,
                               default: '0};
  localparam int SEQ_MAX = SETUP_CYC + STROBE_CYC + HOLD_CYC + 2;

  seq_s s_r;
  seq_s s_nxt;

  // ********************************
  // cycle sequencing
  // ********************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'h0;
    s_nxt.dq_s1 = cif.dq_i;
    s_nxt.dq_s2 = s_r.dq_s1;
    case (s_r.st)
      S_IDLE: begin
        if (cif.req) begin
          s_nxt.wr = cif.wr;
          s_nxt.byte_n = ~cif.byte_m;
          s_nxt.ce_n = 1'h0;
          s_nxt.cnt = SEQ_CNT_W'(SETUP_CYC - 1);
          s_nxt.st = S_SETUP;
          if (cif.byte_m) begin
            // top data pin becomes the lowest address bit, upper lines float
            s_nxt.pin_addr = cif.addr[USER_ADDR_W-1:1];
            s_nxt.dq_o = {cif.addr[0], cif.wdata[DATA_W-2:0]};
            s_nxt.dq_oe = '0;
            s_nxt.dq_oe[LOW_W-1:0] = {LOW_W{cif.wr}};
            s_nxt.dq_oe[DATA_W-1] = 1'h1;
          end else begin
            s_nxt.pin_addr = cif.addr[PIN_ADDR_W-1:0];
            s_nxt.dq_o = cif.wdata;
            s_nxt.dq_oe = {DATA_W{cif.wr}};
          end
        end
      end
      S_SETUP: begin
        if (s_r.cnt == '0) begin
          s_nxt.we_n = ~s_r.wr;
          s_nxt.oe_n = s_r.wr;
          s_nxt.cnt = SEQ_CNT_W'(STROBE_CYC - 1);
          s_nxt.st = S_STROBE;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'h1;
        end
      end
      S_STROBE: begin
        if (s_r.cnt == '0) begin
          s_nxt.we_n = 1'h1;
          s_nxt.oe_n = 1'h1;
          // in byte width only the low lines carry data
          s_nxt.rdata = s_r.byte_n ? s_r.dq_s2 : DATA_W'(s_r.dq_s2[LOW_W-1:0]);
          s_nxt.cnt = SEQ_CNT_W'(HOLD_CYC - 1);
          s_nxt.st = S_HOLD;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'h1;
        end
      end
      default: begin
        if (s_r.cnt == '0) begin
          s_nxt.ce_n = 1'h1;
          s_nxt.dq_oe = '0;
          s_nxt.done = 1'h1;
          s_nxt.st = S_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= SEQ_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cif.done = s_r.done;
  assign cif.rdata = s_r.rdata;
  assign cif.ce_n = s_r.ce_n;
  assign cif.oe_n = s_r.oe_n;
  assign cif.we_n = s_r.we_n;
  assign cif.byte_n = s_r.byte_n;
  assign cif.pin_addr = s_r.pin_addr;
  assign cif.dq_o = s_r.dq_o;
  assign cif.dq_oe = s_r.dq_oe;

  // ********************************
  // checks
  // ********************************
  AST_BYTE_PINS: assert property (@(posedge clk) disable iff (rst)
    (!s_r.ce_n && !s_r.byte_n) |-> (s_r.dq_oe[DATA_W-1] && s_r.dq_oe[DATA_W-2:LOW_W] == '0))
    else $error("byte width pin drive wrong");
  // in byte width the top pin still carries the low address while the device drives
  AST_READ_FLOAT: assert property (@(posedge clk) disable iff (rst)
    !s_r.oe_n |-> (s_r.dq_oe == {!s_r.byte_n, {(DATA_W-1){1'h0}}} && s_r.we_n))
    else $error("host drives data during a read strobe");
  AST_CYCLE_DONE: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == S_IDLE && cif.req) |-> ##[1:SEQ_MAX] s_r.done)
    else $error("bus cycle did not finish in time");

endmodule

// ---- verif/flash_dev_model.sv ----
// behavioural boot-block flash device facing the host controller
`timescale 1ns/1ns
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h3A, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'h5C, // arbitrary value
  parameter logic [7:0] ID_HI = 8'h11, // arbitrary value
  parameter logic [7:0] ID_OP = 8'h90,
  parameter logic [18:0] BOOT_W = 19'h7E000
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_powerdown_n,
  input wire logic wp,
  input wire logic byte_n,
  input wire logic id_hv,
  input wire logic vpp,
  input wire logic [PIN_ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic [DATA_W-1:0] dq_oe,
  output logic [DATA_W-1:0] dq_i,
  output int errs
);
  typedef enum logic [2:0] {M_ARRAY, M_ID, M_STAT, M_PROG, M_ERASE} mode_e;
  mode_e mode = M_ARRAY;
  logic [15:0] mem [int];
  logic [15:0] dv, den, rw, w;
  logic [15:0] last = 16'h0000;
  logic busy = 1'b0;
  int upd = 0;

  initial errs = 0;

  always @(negedge reset_powerdown_n) begin
    mode = M_ARRAY;
    busy = 1'b0;
  end

  always @(negedge vpp) begin
    if (busy) errs++;
  end

  // ********************************
  // write side
  // ********************************
  always @(posedge we_n) begin
    if (!ce_n && reset_powerdown_n) begin
      w = mem.exists(addr) ? mem[addr] : 16'hFFFF;
      if (mode == M_PROG || mode == M_ERASE) begin
        if (!vpp) errs++;
        if (mode == M_ERASE && dq_i[7:0] != 8'hD0) errs++;
        if (addr < BOOT_W || wp) begin
          if (mode == M_ERASE) begin
            // only written words need resetting, the rest read erased anyway
            foreach (mem[k])
              if (k[18:13] == addr[18:13]) mem[k] = 16'hFFFF;
          end else if (byte_n) mem[addr] = w & dq_i;
          else if (dq_i[15]) mem[addr] = {w[15:8] & dq_i[7:0], w[7:0]};
          else mem[addr] = {w[15:8], w[7:0] & dq_i[7:0]};
        end
        mode = M_STAT;
        busy = 1'b1;
        busy <= #100 1'b0;
      end else begin
        case (dq_i[7:0])
          8'h20: mode = M_ERASE;
          8'h10, 8'h40: mode = M_PROG;
          8'hFF: mode = M_ARRAY;
          ID_OP: mode = M_ID;
          8'hD0: errs++;
          default: ;
        endcase
      end
      upd++;
    end
  end

  // ********************************
  // read side
  // ********************************
  always @(ce_n, oe_n, we_n, reset_powerdown_n, addr, byte_n, id_hv,
           dq_o, dq_oe, mode, upd) begin
    rw = mem.exists(addr) ? mem[addr] : 16'hFFFF;
    if (id_hv || mode == M_ID)
      dv = {byte_n ? ID_HI : 8'h00, addr[0] ? PART_CODE : MAKER_CODE};
    else if (mode == M_STAT) dv = 16'h0080;
    else if (byte_n) dv = rw;
    else dv = {8'h00, dq_o[15] ? rw[15:8] : rw[7:0]};
    den = (!ce_n && !oe_n && we_n && reset_powerdown_n) ? {{8{byte_n}}, 8'hFF}
                                                        : 16'h0000;
    if (|(den & dq_oe)) errs++;
    last = (dv & den) | (last & ~den);
    // no pull resistors: undriven lines show the inverse of their last level
    dq_i = (dq_o & dq_oe) | (dv & den & ~dq_oe) | (~last & ~den & ~dq_oe);
  end
endmodule

// ---- verif/flash_host_ctrl_tb.sv ----
// self-checking bench for the flash host controller against the device model
`timescale 1ns/1ns
module flash_host_ctrl_tb;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER = 8'h3A; // arbitrary value
  localparam logic [7:0] PART = 8'h5C; // arbitrary value
  localparam logic [7:0] ID_HI = 8'h11; // arbitrary value
  localparam logic [18:0] BOOT_W = 19'h7E000;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic REQ_VALID = 1'b0;
  logic REQ_BOOT = 1'b0;
  logic BYTE_MODE = 1'b0;
  logic [2:0] REQ_OP = 3'h0;
  logic [USER_ADDR_W-1:0] REQ_ADDR = 20'h00000;
  logic [DATA_W-1:0] REQ_WDATA = 16'h0000;
  logic REQ_READY, RSP_VALID, FL_CE_N, FL_OE_N, FL_WE_N, FL_RESET_POWERDOWN_N, FL_WP;
  logic FL_BYTE_N, FL_ID_ELEVATED_VOLTAGE, FL_VPP_EN;
  logic [DATA_W-1:0] RSP_DATA, FL_DQ_O, FL_DQ_OE, FL_DQ_I;
  logic [PIN_ADDR_W-1:0] FL_ADDR;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  int mdl_errs;
  logic [31:0] seed = 32'h4FB5;
  logic [15:0] xmem [int];

  always #10 CLOCK = ~CLOCK;

  flash_host_ctrl #(.PROG_WAIT_CYC(20), .ERASE_WAIT_CYC(30), .ID_CMD(CMD_IDENTIFY_DEF)) dut_u (
    .CLOCK(CLOCK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP), .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA), .REQ_BOOT(REQ_BOOT), .BYTE_MODE(BYTE_MODE), .REQ_READY(REQ_READY),
    .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N),
    .FL_WE_N(FL_WE_N), .FL_RESET_POWERDOWN_N(FL_RESET_POWERDOWN_N), .FL_WP(FL_WP),
    .FL_BYTE_N(FL_BYTE_N), .FL_ID_ELEVATED_VOLTAGE(FL_ID_ELEVATED_VOLTAGE),
    .FL_VPP_EN(FL_VPP_EN), .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE),
    .FL_DQ_I(FL_DQ_I));
  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .ID_HI(ID_HI),
    .ID_OP(CMD_IDENTIFY_DEF), .BOOT_W(BOOT_W)) mdl_u (
    .ce_n(FL_CE_N), .oe_n(FL_OE_N), .we_n(FL_WE_N), .wp(FL_WP),
    .reset_powerdown_n(FL_RESET_POWERDOWN_N),
    .byte_n(FL_BYTE_N), .id_hv(FL_ID_ELEVATED_VOLTAGE), .vpp(FL_VPP_EN), .addr(FL_ADDR),
    .dq_o(FL_DQ_O), .dq_oe(FL_DQ_OE), .dq_i(FL_DQ_I), .errs(mdl_errs));

  // ********************************
  // expectations
  // ********************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] getw(input logic [18:0] a);
    return xmem.exists(a) ? xmem[a] : 16'hFFFF;
  endfunction

  function automatic logic [15:0] exp_read(input logic [19:0] a, input logic bm);
    logic [15:0] w;
    w = getw(bm ? a[19:1] : a[18:0]);
    return bm ? {8'h00, a[0] ? w[15:8] : w[7:0]} : w;
  endfunction

  function automatic logic [15:0] exp_id(input logic [19:0] a, input logic bm);
    return {bm ? 8'h00 : ID_HI, (bm ? a[1] : a[0]) ? PART : MAKER};
  endfunction

  task automatic exp_write(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d,
                           input logic bm, input logic boot);
    logic [18:0] wa;
    logic [15:0] w;
    wa = bm ? a[19:1] : a[18:0];
    w = getw(wa);
    if (wa >= BOOT_W && !boot) return;
    if (op == 3'h2) begin
      foreach (xmem[k])
        if (k[18:13] == wa[18:13]) xmem[k] = 16'hFFFF;
    end else if (!bm) xmem[wa] = w & d;
    else if (a[0]) xmem[wa] = {w[15:8] & d[7:0], w[7:0]};
    else xmem[wa] = {w[15:8], w[7:0] & d[7:0]};
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic tick;
    @(posedge CLOCK);
    #1;
  endtask

  // ********************************
  // one user request, taken and, except for reset or an unknown op, answered
  // ********************************
  task automatic run(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d,
                     input logic bm, input logic boot);
    int n;
    n = 0;
    while (REQ_READY !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    REQ_OP = op;
    REQ_ADDR = a;
    REQ_WDATA = d;
    BYTE_MODE = bm;
    REQ_BOOT = boot;
    REQ_VALID = 1'b1;
    tick();
    REQ_VALID = 1'b0;
    if (op > 3'h5) begin
      // valid stays low a whole cycle before the next request, and no bus cycle starts
      tick();
      check({REQ_READY, RSP_VALID, FL_CE_N}, 3'h5);
      return;
    end
    if (op == 3'h5) begin
      tick();
      check({FL_RESET_POWERDOWN_N, FL_DQ_OE}, 17'h00000);
      return;
    end
    n = 0;
    while (RSP_VALID !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    if (op == 3'h1 || op == 3'h2) exp_write(op, a, d, bm, boot);
    if (op == 3'h0) check({RSP_VALID, RSP_DATA}, {1'b1, exp_read(a, bm)});
    else if (op > 3'h2) check({RSP_VALID, RSP_DATA}, {1'b1, exp_id(a, bm)});
    else check({RSP_VALID, RSP_DATA}, 17'h10000);
  endtask

  // host must keep off the data lines while the device may drive them
  always @(posedge CLOCK) begin
    cyc++;
    if (!RST && FL_OE_N === 1'b0)
      check({FL_WE_N, FL_DQ_OE}, {1'b1, FL_BYTE_N === 1'b0 ? 16'h8000 : 16'h0000});
    if (!RST && FL_BYTE_N === 1'b0 && FL_CE_N === 1'b0) check(FL_DQ_OE[14:8], 7'h00);
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  initial begin
    logic [18:0] w;
    logic [19:0] a;
    repeat (12) @(posedge CLOCK);
    #1;
    RST = 1'b0;
    run(3'h0, 20'h00003, 16'h0000, 1'b0, 1'b0);
    run(3'h0, 20'h00007, 16'h0000, 1'b1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      a = i[1] ? {18'h00000, i[0], 1'b0} : {19'h00000, i[0]};
      run(i[2] ? 3'h4 : 3'h3, a, 16'h0000, i[1], 1'b0);
    end
    // locked then unlocked boot program, then locked then unlocked boot erase
    for (int i = 0; i < 4; i++) begin
      run(i[1] ? 3'h2 : 3'h1, {1'b0, BOOT_W}, 16'h1234, 1'b0, i[0]);
      run(3'h0, {1'b0, BOOT_W}, 16'h0000, 1'b0, 1'b0);
    end
    run(3'h1, 20'h00003, 16'h00A5, 1'b1, 1'b0);
    run(3'h0, 20'h00001, 16'h0000, 1'b0, 1'b0);
    run(3'h6, 20'h00000, 16'h0000, 1'b0, 1'b0);
    run(3'h3, 20'h00001, 16'h0000, 1'b0, 1'b0);
    run(3'h5, 20'h00000, 16'h0000, 1'b0, 1'b0);
    run(3'h0, 20'h00001, 16'h0000, 1'b0, 1'b0);
    repeat (80) begin
      seed = lfsr(seed);
      w = (seed[3] ? BOOT_W : 19'h00000) | {16'h0000, seed[6:4]};
      a = seed[7] ? {w, seed[8]} : {1'b0, w};
      run(seed[11:9] > 3'h5 ? 3'h0 : seed[11:9], a, seed[31:16], seed[7], seed[12]);
    end
    RST = 1'b1;
    tick();
    check({FL_RESET_POWERDOWN_N, FL_CE_N, REQ_READY, FL_VPP_EN, FL_DQ_OE}, 20'h40000);
    tick();
    RST = 1'b0;
    run(3'h0, 20'h00001, 16'h0000, 1'b0, 1'b0);
    check(mdl_errs, 0);
    tally_and_finish();
  end
endmodule
